// File: hw/sfpc_pkg.sv
// Package for the status flags and program counter block.
// Assumes an 8-bit data path and a 15-bit program counter.
package sfpc_pkg;
   // ==========================================================
   // Register offsets (word index, byte address = 4 * index)
   localparam logic [3:0] OFF_FLAGS  = 4'h0;
   localparam logic [3:0] OFF_PCLOW  = 4'h1;
   localparam logic [3:0] OFF_LATCH  = 4'h2;
   localparam logic [3:0] OFF_PCFULL = 4'h3;
   // ==========================================================
   // Flag bit positions
   localparam int BIT_CARRY = 0;
   localparam int BIT_DC    = 1;
   localparam int BIT_ZERO  = 2;
   localparam int BIT_PD    = 3;
   localparam int BIT_TO    = 4;
   // ==========================================================
   // Widths and reset values
   localparam int PC_W = 15;
   localparam logic [7:0]  FLAGS_RST = 8'h18;
   localparam logic [14:0] PC_RST    = 15'h0000;
   localparam logic [6:0]  LATCH_RST = 7'h00;
   // ==========================================================
   // Program counter operations
   typedef enum logic [2:0] {
      PC_STEP = 3'h1,
      PC_JUMP = 3'h2,
      PC_HOLD = 3'h4
   } sfpc_op_t;
endpackage : sfpc_pkg

// File: hw/sfpc_alu_if.sv
// Interface carrying ALU result flags to the flag register.
// Assumes driver and receiver share clk_i.
`timescale 1ns/1ns
interface sfpc_alu_if;
   logic       upd;
   logic       carry;
   logic       dc;
   logic       zero;
   modport src (output upd, output carry, output dc, output zero);
   modport dst (input upd, input carry, input dc, input zero);
endinterface : sfpc_alu_if

// File: hw/sfpc_alu.sv
// Adder/subtractor producing carry, digit carry and zero.
// Assumes operands stable while en_i is high.
`timescale 1ns/1ns
module sfpc_alu (
   // Operands
   input  wire logic [7:0] a_i,
   input  wire logic [7:0] b_i,
   input  wire logic       sub_i,
   input  wire logic       en_i,
   // Result
   output logic      [7:0] res_o,
   sfpc_alu_if.src         fl
);
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] bb;
   always_comb begin
      bb    = sub_i ? ~b_i : b_i;
      sum   = {1'b0, a_i} + {1'b0, bb} + {8'h00, sub_i};
      nib   = {1'b0, a_i[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub_i};
      res_o = sum[7:0];
      // Carry set means no borrow in subtraction [RULE4]
      fl.carry = sum[8];
      fl.dc    = nib[4];
      fl.zero  = (sum[7:0] == 8'h00);
      fl.upd   = en_i;
   end
endmodule : sfpc_alu

// File: hw/sfpc_top.sv
// Status flags and program counter with classic Wishbone register access.
// Assumes core inputs are on clk_i; sleep/timeout events are one-cycle pulses.
//
// Behaviour
// RULE1 - Flag register writable like any register
// RULE2 - ALU-updating write keeps computed Z, DC, C
// RULE3 - Timeout and power-down bits ignore writes
// RULE4 - Subtraction carry and digit carry mean no-borrow
// RULE5 - Program counter is fifteen bits
// RULE6 - Counter low byte readable and writable
// RULE7 - Upper counter bits only via high latch (reads at OFF_PCFULL also return all 15 counter bits directly)
// RULE8 - Every reset clears program counter
// RULE9 - Unmapped locations read as zero
// RULE10 - Low byte write loads upper from latch
// RULE11 - Counter advances one per fetch
`timescale 1ns/1ns
module sfpc_top (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Core control
   input  wire logic        fetch_i,
   input  wire logic        jump_i,
   input  wire logic [14:0] jump_addr_i,
   input  wire logic        alu_en_i,
   input  wire logic        alu_sub_i,
   input  wire logic [7:0]  alu_a_i,
   input  wire logic [7:0]  alu_b_i,
   input  wire logic        sleep_i,
   input  wire logic        wdt_timeout_i,
   input  wire logic        clr_wdt_i,
   // Core outputs
   output logic      [14:0] pc_o,
   output logic      [7:0]  flags_o,
   output logic      [7:0]  alu_res_o
);
   typedef struct packed {
      logic [7:0]  flags;
      logic [14:0] pc;
      logic [6:0]  latch;
      logic [31:0] rdat;
      logic        ack;
      logic [7:0]  res;
   } sfpc_state_t;

   sfpc_state_t s_q;
   sfpc_state_t s_d;
   sfpc_alu_if  alu_fl ();
   logic [7:0]  res_w;
   logic [3:0]  idx;
   logic        wr;
   logic        rd;
   sfpc_pkg::sfpc_op_t op;

   // ==========================================================
   // ALU
   sfpc_alu u_alu (
      .a_i   (alu_a_i),
      .b_i   (alu_b_i),
      .sub_i (alu_sub_i),
      .en_i  (alu_en_i),
      .res_o (res_w),
      .fl    (alu_fl)
   );

   // ==========================================================
   // Next state
   always_comb begin
      s_d = s_q;
      idx = wb_adr_i[5:2];
      wr  = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.ack && wb_sel_i[0];
      rd  = wb_cyc_i && wb_stb_i && !wb_we_i && !s_q.ack;
      s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
      s_d.res = res_w;
      // Flag register takes writes like other registers [RULE1]
      if (wr && idx == sfpc_pkg::OFF_FLAGS) begin
         s_d.flags[7:5] = wb_dat_i[7:5];
         s_d.flags[sfpc_pkg::BIT_CARRY] = wb_dat_i[sfpc_pkg::BIT_CARRY];
         s_d.flags[sfpc_pkg::BIT_DC]    = wb_dat_i[sfpc_pkg::BIT_DC];
         s_d.flags[sfpc_pkg::BIT_ZERO]  = wb_dat_i[sfpc_pkg::BIT_ZERO];
      end
      // Computed flags override written data [RULE2] [RULE4]
      if (alu_fl.upd) begin
         s_d.flags[sfpc_pkg::BIT_CARRY] = alu_fl.carry;
         s_d.flags[sfpc_pkg::BIT_DC]    = alu_fl.dc;
         s_d.flags[sfpc_pkg::BIT_ZERO]  = alu_fl.zero;
      end
      // Status bits change only from reset, sleep and watchdog logic [RULE3]
      if (clr_wdt_i) begin
         s_d.flags[sfpc_pkg::BIT_TO] = 1'b1;
         s_d.flags[sfpc_pkg::BIT_PD] = 1'b1;
      end
      if (sleep_i) begin
         s_d.flags[sfpc_pkg::BIT_PD] = 1'b0;
      end
      if (wdt_timeout_i) begin
         s_d.flags[sfpc_pkg::BIT_TO] = 1'b0;
      end
      if (wr && idx == sfpc_pkg::OFF_LATCH) begin
         s_d.latch = wb_dat_i[6:0];
      end
      if (jump_i) begin
         op = sfpc_pkg::PC_JUMP;
      end else if (fetch_i) begin
         op = sfpc_pkg::PC_STEP;
      end else begin
         op = sfpc_pkg::PC_HOLD;
      end
      unique case (op)
         sfpc_pkg::PC_STEP: begin
            s_d.pc = s_q.pc + 15'h0001; // [RULE11] [RULE5]
         end
         sfpc_pkg::PC_JUMP: begin
            s_d.pc = jump_addr_i;
         end
         sfpc_pkg::PC_HOLD: begin
            s_d.pc = s_q.pc;
         end
      endcase
      // Low byte write jumps with latch as upper bits [RULE6] [RULE10] [RULE7]
      if (wr && idx == sfpc_pkg::OFF_PCLOW) begin
         s_d.pc = {s_q.latch, wb_dat_i[7:0]};
      end
      if (rd) begin
         unique case (idx)
            sfpc_pkg::OFF_FLAGS:  s_d.rdat = {24'h000000, s_q.flags};
            sfpc_pkg::OFF_PCLOW:  s_d.rdat = {24'h000000, s_q.pc[7:0]};
            sfpc_pkg::OFF_LATCH:  s_d.rdat = {25'h0000000, s_q.latch};
            sfpc_pkg::OFF_PCFULL: s_d.rdat = {17'h00000, s_q.pc};
            default:              s_d.rdat = 32'h00000000; // [RULE9]
         endcase
      end
      if (rst_i) begin
         s_d.flags = sfpc_pkg::FLAGS_RST;
         s_d.pc    = sfpc_pkg::PC_RST; // [RULE8]
         s_d.latch = sfpc_pkg::LATCH_RST;
         s_d.rdat  = 32'h00000000;
         s_d.ack   = 1'b0;
         s_d.res   = 8'h00;
      end
   end

   always_ff @(posedge clk_i) begin
      s_q <= s_d;
   end

   // ==========================================================
   // Outputs
   always_comb begin
      wb_dat_o  = s_q.rdat;
      wb_ack_o  = s_q.ack;
      pc_o      = s_q.pc;
      flags_o   = s_q.flags;
      alu_res_o = s_q.res;
   end
endmodule : sfpc_top

// File: tb/sfpc_chk.sv
// Checker for sfpc_top, watching only its ports.
// Assumes the master drops stb for one cycle after each ack.
`timescale 1ns/1ns
module sfpc_chk (
   input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
   input wire logic [5:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i, wb_dat_o,
   input wire logic        fetch_i, jump_i, alu_en_i, alu_sub_i,
   input wire logic        sleep_i, wdt_timeout_i, clr_wdt_i,
   input wire logic [14:0] jump_addr_i, pc_o,
   input wire logic [7:0]  alu_a_i, alu_b_i, flags_o
);
   logic       take, wr, wr_pcl, wr_flg;
   logic [2:0] sub_exp;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = take && wb_we_i && wb_sel_i[0];
   assign wr_pcl = wr && wb_adr_i[5:2] == sfpc_pkg::OFF_PCLOW;
   assign wr_flg = wr && wb_adr_i[5:2] == sfpc_pkg::OFF_FLAGS;
   assign sub_exp = {alu_a_i == alu_b_i, alu_a_i[3:0] >= alu_b_i[3:0], alu_a_i >= alu_b_i};
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   bus_ack_a: assert property (take |=> ack_pulse) else $error("ack pulse");
   pc_reset_a: assert property (disable iff (1'b0) rst_i |=> pc_o == 15'h0000)
      else $error("pc reset");
   pc_step_a: assert property (fetch_i && !jump_i && !wr_pcl |=> pc_o == $past(pc_o) + 15'h0001)
      else $error("pc step");
   pc_hold_a: assert property (!fetch_i && !jump_i && !wr_pcl |=> $stable(pc_o))
      else $error("pc hold");
   pc_jump_a: assert property (jump_i && !wr_pcl |=> pc_o == $past(jump_addr_i))
      else $error("pc jump");
   pcl_load_a: assert property (wr_pcl |=> pc_o[7:0] == $past(wb_dat_i[7:0], 1))
      else $error("pc low load");
   ro_bits_a: assert property (wr_flg && !sleep_i && !wdt_timeout_i && !clr_wdt_i
      |=> flags_o[4:3] == $past(flags_o[4:3])) else $error("status bits written");
   flag_wr_a: assert property (wr_flg && !alu_en_i |=> flags_o[7:5] == $past(wb_dat_i[7:5]))
      else $error("flag write");
   sub_flags_a: assert property (alu_en_i && alu_sub_i |=> flags_o[2:0] == $past(sub_exp))
      else $error("sub flags");
   unmap_rd_a: assert property (take && !wb_we_i && wb_adr_i[5:2] > 4'h3 |=> wb_dat_o == 32'h0)
      else $error("unmapped read");
endmodule : sfpc_chk
bind sfpc_top sfpc_chk sfpc_chk_inst (.*);

// File: tb/testbench.sv
// Self-checking bench for sfpc_top over Wishbone and core pins.
// Assumes ack one cycle after the request is taken.
`timescale 1ns/1ns
module testbench;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fetch_i, jump_i;
   logic        alu_en_i, alu_sub_i, sleep_i, wdt_timeout_i, clr_wdt_i;
   logic [5:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [14:0] jump_addr_i, pc_o;
   logic [7:0]  alu_a_i, alu_b_i, flags_o, alu_res_o;
   int          errors, cmp_count;
   sfpc_top sfpc_top_inst (.*);
   // ==========================================================
   // Clock and helpers
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   task automatic stop_test;
      if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wb(input logic [3:0] idx, input logic we, input logic [7:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'h0};
      wb_dat_i <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
      wb(idx, 1'b0, 8'h00);
      chk(q, exp);
   endtask : rd
   task automatic pulse(input logic j, input logic [14:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      jump_i <= j;
      fetch_i <= !j;
      jump_addr_i <= a;
      @(posedge clk_i);
      jump_i <= 1'b0;
      fetch_i <= 1'b0;
      @(negedge clk_i);
      chk(32'(pc_o), exp);
   endtask : pulse
   task automatic do_reset;
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : do_reset
   task automatic alu(input logic [7:0] a, b, r, input logic w, input logic [31:0] exp);
      @(posedge clk_i);
      alu_en_i <= 1'b1;
      alu_a_i <= a;
      alu_b_i <= b;
      if (w) wb(4'h0, 1'b1, 8'h00);
      @(posedge clk_i);
      alu_en_i <= 1'b0;
      rd(4'h0, exp);
      chk(32'(alu_res_o), 32'(r));
   endtask : alu
   // ==========================================================
   // Scenarios
   task automatic t_flags;
      rd(4'h0, 32'h18);
      wb(4'h0, 1'b1, 8'h00);
      rd(4'h0, 32'h18);
      wb(4'h0, 1'b1, 8'hE7);
      rd(4'h0, 32'hFF);
   endtask : t_flags
   task automatic t_alu;
      alu(8'h05, 8'h05, 8'h00, 1'b1, 32'h1F);
      alu(8'h10, 8'h01, 8'h0F, 1'b0, 32'h19);
      alu(8'h01, 8'h02, 8'hFF, 1'b0, 32'h18);
      alu_sub_i <= 1'b0;
      alu(8'hF0, 8'h20, 8'h10, 1'b0, 32'h19);
      alu_sub_i <= 1'b1;
   endtask : t_alu
   task automatic t_pc;
      wb(4'h2, 1'b1, 8'h55);
      wb(4'h1, 1'b1, 8'hAA);
      chk(32'(pc_o), 32'h55AA);
      rd(4'h3, 32'h55AA);
      rd(4'h1, 32'hAA);
      pulse(1'b0, 15'h0000, 32'h55AB);
      pulse(1'b1, 15'h7FFF, 32'h7FFF);
      pulse(1'b0, 15'h0000, 32'h0);
   endtask : t_pc
   task automatic t_unmap;
      wb(4'h5, 1'b1, 8'hFF);
      rd(4'h5, 32'h0);
      rd(4'hF, 32'h0);
      wb(4'h1, 1'b1, 8'h33);
      do_reset;
      @(negedge clk_i);
      chk(32'(pc_o), 32'h0);
   endtask : t_unmap
   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, fetch_i, jump_i, alu_en_i} = 7'h40;
      {sleep_i, wdt_timeout_i, clr_wdt_i} = 3'h0;
      alu_sub_i = 1'b1;
      {wb_adr_i, wb_dat_i, jump_addr_i, alu_a_i, alu_b_i} = '0;
      wb_sel_i = 4'hF;
      errors = 0;
      cmp_count = 0;
      do_reset;
      t_flags;
      t_alu;
      t_pc;
      t_unmap;
      stop_test;
   end
   initial begin
      repeat (3000) @(posedge clk_i);
      errors++;
      stop_test;
   end
endmodule : testbench
